// ### verilog/flash_prot_pkg.sv
/*
 * Constants for the flash programming protection block: register map,
 * field positions, key codes, reset values and timing figures.
 * Assumes a 32-bit classic Wishbone slave port on a 40 MHz clock.
 */
// Functional notes
// [R1] Download start bit clear holds protection and refuses downloads.
// [R2] Download and program/erase need their own matching key in the key register.
// [R3] Software writes a5 for download, 5a for program/erase, then clears key.
// [R4] A malfunction while programming sets the error flag and aborts the operation.
// [R5] Any interrupt, including nonmaskable, during programming sets the error flag.
// [R6] Any flash read or fetch during programming sets the error flag.
// [R7] Sleep or software standby during programming sets the error flag.
// [R8] A foreign bus master gaining the bus during programming sets the error flag.
// [R9] Error state holds until reset or hardware standby; software cannot clear it.
// [R10] Reset generator holds reset at least 100 us after error protection.
// [R11] Reset and hardware standby initialise registers and enter protection.
// [R12] Array select maps user or user-boot array at 0; boot array blocks programming.
// [R13] Software writes the array select register only from on-chip RAM.
// [R14] Software runs four no-ops from RAM after switching before flash access.
// [R15] Software masks interrupts and avoids nonmaskable ones while switching.
// [R16] Vectors follow the selected array unless RAM vector enable is set.
// [R17] User-boot array is 8 Kbytes; reads beyond return undefined data.
// [R18] Error flag is read-only, cleared only by reset or hardware standby.
package flash_prot_pkg;

    // ********************************
    // Register offsets (byte address)
    // ********************************
    localparam logic [3:0] ctl_status_off   = 4'h0;
    localparam logic [3:0] key_off          = 4'h4;
    localparam logic [3:0] array_sel_off    = 4'h8;
    localparam logic [3:0] status_off       = 4'hc;

    // ********************************
    // Field positions
    // ********************************
    localparam int download_start_bit = 0;
    localparam int ram_vector_bit     = 6;
    localparam int error_flag_bit     = 7;
    localparam int prog_active_bit    = 0;
    localparam int dl_active_bit      = 1;
    localparam int boot_sel_bit       = 2;
    localparam int switching_bit      = 3;

    // ********************************
    // Key codes and reset values
    // ********************************
    localparam logic [7:0] key_download   = 8'ha5;
    localparam logic [7:0] key_program    = 8'h5a;
    localparam logic [7:0] key_reset      = 8'h00;
    localparam logic [7:0] select_user    = 8'h00;
    localparam logic [7:0] select_boot    = 8'haa;
    localparam logic [7:0] select_reset   = 8'h00;

    // ********************************
    // Timing
    // ********************************
    localparam int clk_mhz              = 40;
    localparam int error_reset_us       = 100;
    localparam int error_reset_cycles   = error_reset_us * clk_mhz;
    localparam int switch_time_ns       = 100;
    localparam int clk_period_ns        = 25;
    localparam int switch_cycles        = (switch_time_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [2:0] switch_cnt_init = 3'(switch_cycles);
    localparam int boot_array_bytes     = 8192;
    localparam logic [23:0] boot_limit  = 24'(boot_array_bytes);

    typedef enum logic [1:0] {st_idle, st_download, st_program, st_error} prot_state_e;

endpackage

// ### verilog/flash_error_detect.sv
/*
 * Error event detector: watches the bus and processor event inputs while
 * a program or erase operation runs and registers an error pulse one cycle after each event cycle.
 * Assumes all event inputs are synchronous to clk and already qualified.
 */
`timescale 1ns/100ps
`default_nettype none
module flash_error_detect
    import flash_prot_pkg::*;
(
    // Clock and control
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ce,
    input  wire logic prog_active,
    // Events
    input  wire logic irq_taken,
    input  wire logic nmi_taken,
    input  wire logic flash_read,
    input  wire logic sleep_exec,
    input  wire logic foreign_master,
    input  wire logic malfunction,
    // Result
    output logic      error_pulse_r
);
    always_ff @(posedge clk) begin
        if (reset) begin
            error_pulse_r <= 1'b0;
        end else if (ce) begin
            error_pulse_r <= prog_active &
                             ((irq_taken | nmi_taken)  // R5
                              | flash_read             // R6
                              | sleep_exec             // R7
                              | foreign_master         // R8
                              | malfunction);          // R4
        end
    end
endmodule
`default_nettype wire

// ### verilog/flash_program_protection.sv
/*
 * Flash program/erase protection and memory array switching.
 * Holds the code control/status, key and array select registers, gates
 * download and program/erase, latches the error flag on illegal events and
 * steers address 0 and the vector table between arrays.
 * Assumes classic Wishbone master on clk, and event strobes from the CPU
 * side in the same clock domain. hw_standby acts as a reset.
 */
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module flash_program_protection
    import flash_prot_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        hw_standby,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Operation requests from the flash engine
    input  wire logic        prog_start,
    input  wire logic        prog_done,
    input  wire logic        download_done,
    // Error event inputs
    input  wire logic        irq_taken,
    input  wire logic        nmi_taken,
    input  wire logic        flash_read,
    input  wire logic        sleep_exec,
    input  wire logic        foreign_master,
    input  wire logic        malfunction,
    // Array access
    input  wire logic [23:0] flash_addr,
    // Outputs
    output logic             download_en_r,
    output logic             prog_enable_r,
    output logic             prog_abort_r,
    output logic             flash_error_flag,
    output logic             boot_array_sel_r,
    output logic             vector_in_ram_r,
    output logic             boot_range_err_r,
    output logic             switching_r,
    output logic             long_reset_req_r
);

    // ********************************
    // Registers and state
    // ********************************
    logic        download_start_ctl_r;
    logic        ram_vector_enable_r;
    logic        error_flag_r;
    logic [7:0]  flash_key_reg_r;
    logic [7:0]  array_select_reg_r;
    logic [2:0]  switch_cnt_r;
    prot_state_e state_r;
    prot_state_e state_nxt;
    logic        error_pulse_r;
    logic        init;
    logic        wr;
    logic        rd_req;

    assign init   = reset | hw_standby;  // R11
    // Writes land on the ack edge, where the master samples the answer
    assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign rd_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

    function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
        hit = (adr == off);
    endfunction

    function automatic logic mapped(input logic [3:0] adr);
        mapped = hit(adr, ctl_status_off) | hit(adr, key_off) |
                 hit(adr, array_sel_off) | hit(adr, status_off);
    endfunction

    // ********************************
    // Error detection
    // ********************************
    flash_error_detect u_detect (
        .clk            (clk),
        .reset          (init),
        .ce             (ce),
        .prog_active    (state_r == st_program),
        .irq_taken      (irq_taken),
        .nmi_taken      (nmi_taken),
        .flash_read     (flash_read),
        .sleep_exec     (sleep_exec),
        .foreign_master (foreign_master),
        .malfunction    (malfunction),
        .error_pulse_r  (error_pulse_r)
    );

    // Sticky error flag, only initialisation clears it
    always_ff @(posedge clk) begin
        if (init) begin
            error_flag_r <= 1'b0;  // R18
        end else if (ce && error_pulse_r) begin
            error_flag_r <= 1'b1;  // R4 R9
        end
    end

    // ********************************
    // Control/status register
    // ********************************
    always_ff @(posedge clk) begin
        if (init) begin
            download_start_ctl_r <= 1'b0;
            ram_vector_enable_r  <= 1'b0;
        end else if (ce) begin
            if (wr && hit(wb_adr_i, ctl_status_off)) begin
                // Download start only takes with the download key present
                download_start_ctl_r <= wb_dat_i[download_start_bit]
                                        & (flash_key_reg_r == key_download);  // R2
                ram_vector_enable_r  <= wb_dat_i[ram_vector_bit];
            end else if (download_done) begin
                download_start_ctl_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            flash_key_reg_r <= key_reset;
        end else if (ce && wr && hit(wb_adr_i, key_off)) begin
            flash_key_reg_r <= wb_dat_i[7:0];
        end
    end

    // ********************************
    // Array select and switch window
    // ********************************
    always_ff @(posedge clk) begin
        if (init) begin
            array_select_reg_r <= select_reset;
            switch_cnt_r       <= 3'h0;
        end else if (ce) begin
            if (wr && hit(wb_adr_i, array_sel_off)) begin
                array_select_reg_r <= wb_dat_i[7:0];
                switch_cnt_r       <= switch_cnt_init;
            end else if (switch_cnt_r != 3'h0) begin
                switch_cnt_r <= switch_cnt_r - 3'h1;
            end
        end
    end

    // ********************************
    // Protection state machine
    // ********************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_idle: begin
                // An event caught as program ends still locks the array
                if (error_pulse_r) begin
                    state_nxt = st_error;     // R9
                end else if (download_start_ctl_r && flash_key_reg_r == key_download) begin
                    state_nxt = st_download;  // R1 R2
                end else if (prog_start && flash_key_reg_r == key_program
                             && array_select_reg_r != select_boot) begin
                    state_nxt = st_program;   // R2 R12
                end
            end
            st_download: begin
                if (!download_start_ctl_r || download_done) begin
                    state_nxt = st_idle;      // R1
                end
            end
            st_program: begin
                if (error_pulse_r) begin
                    state_nxt = st_error;     // R4
                end else if (prog_done || flash_key_reg_r != key_program) begin
                    state_nxt = st_idle;
                end
            end
            st_error: state_nxt = st_error;   // R9
            default:  state_nxt = st_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (init) begin
            state_r <= st_idle;  // R11
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ********************************
    // Registered outputs
    // ********************************
    always_ff @(posedge clk) begin
        if (init) begin
            download_en_r    <= 1'b0;
            prog_enable_r    <= 1'b0;
            prog_abort_r     <= 1'b0;
            flash_error_flag <= 1'b0;
            long_reset_req_r <= 1'b0;
        end else if (ce) begin
            download_en_r    <= state_nxt == st_download;
            prog_enable_r    <= state_nxt == st_program;
            prog_abort_r     <= state_nxt == st_error;      // R4
            flash_error_flag <= error_flag_r | error_pulse_r;
            // Asks the reset generator for the long reset
            long_reset_req_r <= state_nxt == st_error;      // R10
        end
    end

    always_ff @(posedge clk) begin
        if (init) begin
            boot_array_sel_r <= 1'b0;
            vector_in_ram_r  <= 1'b0;
            switching_r      <= 1'b0;
            boot_range_err_r <= 1'b0;
        end else if (ce) begin
            boot_array_sel_r <= array_select_reg_r == select_boot;  // R12
            vector_in_ram_r  <= ram_vector_enable_r;                // R16
            switching_r      <= switch_cnt_r != 3'h0;
            // Reads past the boot array are flagged, data stays undefined
            boot_range_err_r <= boot_array_sel_r && flash_addr >= boot_limit;  // R17
        end
    end

    // ********************************
    // Wishbone answer: one wait state, err on unmapped
    // ********************************
    always_ff @(posedge clk) begin
        if (init) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce) begin
            wb_ack_o <= rd_req & mapped(wb_adr_i);
            wb_err_o <= rd_req & ~mapped(wb_adr_i);
            wb_dat_o <= 32'h0;
            if (rd_req && !wb_we_i) begin
                case (wb_adr_i)
                    ctl_status_off: begin
                        wb_dat_o[download_start_bit] <= download_start_ctl_r;
                        wb_dat_o[ram_vector_bit]     <= ram_vector_enable_r;
                        wb_dat_o[error_flag_bit]     <= error_flag_r;  // R18
                    end
                    key_off:       wb_dat_o[7:0] <= flash_key_reg_r;
                    array_sel_off: wb_dat_o[7:0] <= array_select_reg_r;
                    status_off: begin
                        wb_dat_o[prog_active_bit] <= state_r == st_program;
                        wb_dat_o[dl_active_bit]   <= state_r == st_download;
                        wb_dat_o[boot_sel_bit]    <= boot_array_sel_r;
                        wb_dat_o[switching_bit]   <= switch_cnt_r != 3'h0;
                    end
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ### testbench/flash_prot_properties.sv
/* Port checker for flash_program_protection, bound into every instance.
   Assumes one clock; reset and hw_standby both clear all state. */
`timescale 1ns/100ps
`default_nettype none
module flash_prot_properties (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hw_standby,
    input wire logic        ce,
    // Bus handshake
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // Events and array address
    input wire logic        irq_taken,
    input wire logic        nmi_taken,
    input wire logic        flash_read,
    input wire logic        sleep_exec,
    input wire logic        foreign_master,
    input wire logic        malfunction,
    input wire logic [23:0] flash_addr,
    // Protection outputs
    input wire logic        download_en_r,
    input wire logic        prog_enable_r,
    input wire logic        prog_abort_r,
    input wire logic        flash_error_flag,
    input wire logic        boot_array_sel_r,
    input wire logic        vector_in_ram_r,
    input wire logic        boot_range_err_r,
    input wire logic        switching_r,
    input wire logic        long_reset_req_r
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (reset || hw_standby);
    logic      rst_seen_r;
    wire logic any_event = irq_taken | nmi_taken | flash_read | sleep_exec
                         | foreign_master | malfunction;
    // Remembers a reset so the first edge after release is checked
    always_ff @(posedge clk) begin
        rst_seen_r <= reset | hw_standby;
    end
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o)
        else $error("ack longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce
        |=> wb_ack_o ^ wb_err_o) else $error("bus answer missing");
    error_event_a: assert property (prog_enable_r && any_event && ce
        |-> ##[1:3] flash_error_flag) else $error("event did not set error flag");
    flag_sticky_a: assert property (flash_error_flag |=> flash_error_flag)
        else $error("error flag cleared without reset");
    abort_tied_a: assert property (flash_error_flag
        |-> prog_abort_r && long_reset_req_r && !prog_enable_r) else $error("no abort");
    reset_init_a: assert property (rst_seen_r |-> !(flash_error_flag | download_en_r
        | prog_enable_r | boot_array_sel_r | vector_in_ram_r | switching_r))
        else $error("state not cleared by reset");
    boot_no_prog_a: assert property ($rose(prog_enable_r) |-> !boot_array_sel_r)
        else $error("programming with boot array");
    switch_window_a: assert property ($rose(switching_r)
        |-> switching_r[*4] ##1 !switching_r) else $error("switch window length");
    boot_range_a: assert property (boot_array_sel_r && flash_addr >= 24'h002000 && ce
        |=> boot_range_err_r) else $error("boot range not flagged");
    cover property (prog_enable_r && any_event);
    cover property ($rose(download_en_r));
    cover property ($rose(switching_r));
endmodule
bind flash_program_protection flash_prot_properties u_props (
    .clk, .reset, .hw_standby, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
    .irq_taken, .nmi_taken, .flash_read, .sleep_exec, .foreign_master, .malfunction,
    .flash_addr, .download_en_r, .prog_enable_r, .prog_abort_r, .flash_error_flag,
    .boot_array_sel_r, .vector_in_ram_r, .boot_range_err_r, .switching_r,
    .long_reset_req_r
);
`default_nettype wire

// ### testbench/cpu_event_model.sv
/* Model of the processor side raising illegal events on command.
   Assumes fire is a one-cycle strobe from the bench on clk. */
`timescale 1ns/100ps
`default_nettype none
module cpu_event_model (
    // Clock and command
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic [2:0] kind,
    input  wire logic       switching_r,
    // Events: irq, nmi, read, sleep, foreign master, malfunction
    output var  logic [5:0] events
);
    initial events = 6'h00;
    // Software never lets events or flash reads land inside a switch
    always @(posedge clk) begin
        events <= (fire && !switching_r) ? (6'h01 << kind) : 6'h00;
    end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
/* Self-checking bench for flash_program_protection against a reference model.
   Assumes the checker and the event model are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import flash_prot_pkg::*;
;
    logic        clk, reset, hw_standby, wb_cyc_i, wb_stb_i, wb_we_i, bus_err;
    logic [3:0]  wb_adr_i, strb;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [23:0] flash_addr;
    logic [5:0]  ev;
    logic [2:0]  kind;
    logic [7:0]  key_m;
    logic        start_m, vec_m, flag_m, wb_ack_o, wb_err_o, download_en_r, prog_enable_r;
    logic        prog_abort_r, flash_error_flag, boot_array_sel_r, vector_in_ram_r;
    logic        boot_range_err_r, switching_r, long_reset_req_r;
    int          miscompares, tests_run, cycles;
    flash_program_protection u_dut (.clk(clk), .reset(reset), .ce(1'b1),
        .hw_standby(hw_standby), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .prog_start(strb[0]), .download_done(strb[1]), .prog_done(strb[2]),
        .irq_taken(ev[0]), .nmi_taken(ev[1]), .flash_read(ev[2]), .sleep_exec(ev[3]),
        .foreign_master(ev[4]), .malfunction(ev[5]), .flash_addr(flash_addr),
        .download_en_r(download_en_r), .prog_enable_r(prog_enable_r),
        .prog_abort_r(prog_abort_r), .flash_error_flag(flash_error_flag),
        .boot_array_sel_r(boot_array_sel_r), .vector_in_ram_r(vector_in_ram_r),
        .boot_range_err_r(boot_range_err_r), .switching_r(switching_r),
        .long_reset_req_r(long_reset_req_r));
    cpu_event_model u_cpu (.clk(clk), .fire(strb[3]), .kind(kind),
        .switching_r(switching_r), .events(ev));
    // ****************
    // Tasks
    // ****************
    task automatic final_report;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ctl_exp();
        return {24'h000000, flag_m, vec_m, 5'h00, start_m};
    endfunction
    // Request held until ack or err is sampled high, model updated then
    task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d);
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        bus_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (we && adr == key_off) key_m = d;
        if (we && adr == ctl_status_off) begin
            start_m = d[download_start_bit] && key_m == key_download;
            vec_m = d[ram_vector_bit];
        end
        @(posedge clk);
    endtask
    task automatic strobe(input logic [3:0] m);
        strb <= m;
        @(posedge clk);
        strb <= 4'h0;
        repeat (6) @(posedge clk);
    endtask
    task automatic tb_reset(input logic hw, input int n);
        hw_standby <= hw;
        reset <= !hw;
        repeat (n) @(posedge clk);
        hw_standby <= 1'b0;
        reset <= 1'b0;
        {start_m, vec_m, flag_m} = 3'h0;
        key_m = key_reset;
        @(posedge clk);
    endtask
    // ****************
    // Stimulus
    // ****************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        {reset, hw_standby, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
        {strb, kind, wb_adr_i, wb_dat_i, flash_addr} = '0;
        void'($urandom(32'ha1d9));
        tb_reset(1'b0, 16);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 4'(i * 4), 8'h00);
            chk(rd, 32'h0);
        end
        wb(1'b0, 4'h2, 8'h00);
        chk(bus_err, 32'h1);
        wb(1'b1, ctl_status_off, 8'h01);
        wb(1'b1, key_off, 8'($urandom_range(8'h5a)));
        wb(1'b1, ctl_status_off, 8'h01);
        repeat (2) @(posedge clk);
        chk(download_en_r, 32'h0);
        wb(1'b1, key_off, key_download);
        wb(1'b1, ctl_status_off, 8'h01);
        repeat (2) @(posedge clk);
        chk(download_en_r, 32'h1);
        strobe(4'h2);
        start_m = 1'b0;
        chk(download_en_r, 32'h0);
        wb(1'b0, ctl_status_off, 8'h00);
        chk(rd, ctl_exp());
        wb(1'b1, key_off, key_reset);
        strobe(4'h8);
        chk(flash_error_flag, 32'h0);
        for (int k = 0; k < 6; k++) begin
            wb(1'b1, key_off, key_program);
            strobe(4'h1);
            chk(prog_enable_r, 32'h1);
            kind <= 3'(k);
            strobe(4'h8);
            flag_m = 1'b1;
            chk({prog_abort_r, long_reset_req_r, flash_error_flag, prog_enable_r}, 32'he);
            wb(1'b1, ctl_status_off, 8'h00);
            wb(1'b0, ctl_status_off, 8'h00);
            chk(rd, ctl_exp());
            tb_reset(k[0], error_reset_cycles);
            chk(flash_error_flag, 32'h0);
        end
        wb(1'b1, array_sel_off, select_boot);
        @(posedge clk);
        chk(switching_r, 32'h1);
        repeat (5) @(posedge clk);
        wb(1'b0, status_off, 8'h00);
        chk(rd, 32'h4);
        wb(1'b1, key_off, key_program);
        strobe(4'h1);
        chk(prog_enable_r, 32'h0);
        flash_addr <= 24'h002000 + 24'($urandom_range(32'h00dfff));
        repeat (2) @(posedge clk);
        chk(boot_range_err_r, 32'h1);
        flash_addr <= 24'($urandom_range(32'h001fff));
        repeat (2) @(posedge clk);
        chk(boot_range_err_r, 32'h0);
        wb(1'b1, ctl_status_off, 8'h40);
        repeat (2) @(posedge clk);
        chk(vector_in_ram_r, 32'h1);
        wb(1'b1, array_sel_off, select_user);
        repeat (6) @(posedge clk);
        chk({boot_array_sel_r, vector_in_ram_r}, 32'h1);
        strobe(4'h1);
        chk(prog_enable_r, 32'h1);
        strobe(4'h4);
        chk(prog_enable_r, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
